// ===== verilog/timer_watchdog_prescaler_irq.sv
// Purpose: 8-bit timer/counter, watchdog, shared prescaler and interrupt control.
// Assumes: Control ops are one-cycle pulses from the core; pins synchronous to clk.
// Notes: The watchdog oscillator is modelled by counting clk, which keeps running in sleep.
`default_nettype none
module timer_watchdog_prescaler_irq
	import timer_irq_pkg::*;
#(
	parameter int WDT_CYCLES = WATCHDOG_TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] work_reg,
	input wire logic cfg_load_op,
	input wire logic timer_wr,
	input wire logic [7:0] timer_wdata,
	input wire logic irq_enable_wr,
	input wire logic irq_flag_wr,
	input wire logic [7:0] power_ctrl_reg,
	input wire logic [7:0] port_change_on,
	input wire logic kick_watchdog_op,
	input wire logic sleep_op,
	input wire logic irq_return_op,
	input wire logic soft_irq_op,
	input wire logic ext_count_pin,
	input wire logic ext_irq_pin,
	input wire logic [7:0] second_port_pins,
	output logic [7:0] timer_count,
	output logic [7:0] irq_enable_rdata,
	output logic [7:0] irq_flag_rdata,
	output logic timeout_status_n,
	output logic sleeping,
	output logic wake,
	output logic vector_valid,
	output logic [11:0] vector_addr,
	output logic watchdog_reset
);
	// Overview: all state lives in one packed struct. One combinational process
	// works out the next copy and one clocked process registers it, so every
	// flop shares the same asynchronous reset and no field has two drivers.
	// Priority inside the next-state process runs from top to bottom: later
	// assignments win. The watchdog time-out sits last because it acts as a
	// device reset and must override any software write landing in that cycle except the count of a timer write.
	// The timer count itself survives a time-out, as the time-out branch leaves tmr alone;
	// software that needs a known count writes it after restart.
	typedef struct packed {
		// Configuration, timer count and its write inhibit
		logic [6:0] cfg;
		logic [7:0] tmr;
		logic [1:0] inhibit;
		// Shared prescaler and watchdog base counter
		logic [7:0] psc;
		logic [31:0] wdt_cnt;
		// Interrupt enables, flags, status and power state
		logic global_irq_on;
		logic [2:0] en;
		logic [2:0] flags;
		logic to_n;
		logic sleeping;
		// Pin synchronisers and their delayed copies for edge detect
		logic cnt_s1;
		logic cnt_s2;
		logic cnt_prev;
		logic irq_s1;
		logic irq_s2;
		logic irq_prev;
		logic [7:0] port_s1;
		logic [7:0] port_s2;
		logic [7:0] port_prev;
		// One-cycle pulses and the vector they carry
		logic wdt_rst;
		logic vec_valid;
		logic [11:0] vec_addr;
		logic wake;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// Masked low prescaler bits that must reach zero for one output tick
	function automatic logic [7:0] ratio_mask(input logic [2:0] ratio, input logic for_wdt);
		logic [8:0] one_hot;
		one_hot = 9'h001 << (for_wdt ? {1'b0, ratio} : ({1'b0, ratio} + 4'h1));
		ratio_mask = 8'(one_hot - 9'h001);
	endfunction

	// Edge decode shared by the count pin and the interrupt pin; both compare
	// the second synchroniser stage against its delayed copy
	function automatic logic edge_hit(input logic cur, input logic prev, input logic falling);
		edge_hit = falling ? (~cur & prev) : (cur & ~prev);
	endfunction

	// Decoded configuration
	logic prescale_assign;
	logic [2:0] ratio;

	// Timer and prescaler path
	logic src_tick;
	logic psc_in;
	logic psc_out;
	logic [7:0] psc_dec;
	logic timer_inc;

	// Watchdog path
	logic wdt_clear;
	logic wdt_base_tick;
	logic timeout;

	// Interrupt path
	logic pin_edge;
	logic [7:0] port_hit;
	logic port_change;
	logic wake_src;
	logic [2:0] set_flags;
	logic [2:0] pending;
	logic [2:0] flags_kept;

	// Per-pin change detect of the second port; a pin whose change enable
	// is low never reaches the flag, and each pin is one copy of this slice
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_port
			assign port_hit[gi] = (state_reg.port_s2[gi] ^ state_reg.port_prev[gi])
				& port_change_on[gi];
		end
	endgenerate

	// Datapath decode from the registered state
	always_comb begin
		prescale_assign = state_reg.cfg[CFG_ASSIGN_BIT];
		ratio = state_reg.cfg[CFG_RATIO_LSB +: 3];
		// Timer source: counter mode uses the chosen pin edge, timer mode every cycle
		if (state_reg.cfg[CFG_SRC_BIT]) begin
			// Pin already passed two flops, so the edge lags it by two clocks
			src_tick = edge_hit(state_reg.cnt_s2, state_reg.cnt_prev,
				state_reg.cfg[CFG_EDGE_BIT]);
		end else begin
			// The instruction clock stops in sleep, so the timer stands still
			src_tick = ~state_reg.sleeping;
		end

		// A kick or sleep in the same cycle as the base tick wins, so a late
		// kick still keeps the device out of reset
		wdt_clear = kick_watchdog_op || sleep_op;
		wdt_base_tick = power_ctrl_reg[WATCHDOG_ON_BIT] && !wdt_clear
			&& (state_reg.wdt_cnt == 32'(WDT_CYCLES - 1));
		// The prescaler feeds whichever side owns it
		psc_in = prescale_assign ? wdt_base_tick : src_tick;
		psc_dec = state_reg.psc - 8'h01;
		psc_out = psc_in && ((psc_dec & ratio_mask(ratio, prescale_assign)) == 8'h00);
		// One-to-one path when the watchdog owns the prescaler
		timer_inc = (prescale_assign ? src_tick : psc_out) && (state_reg.inhibit == 2'h0);
		timeout = prescale_assign ? psc_out : wdt_base_tick;

		// Interrupt events; the pin edge sense is inverted by the select bit
		pin_edge = edge_hit(state_reg.irq_s2, state_reg.irq_prev,
			!state_reg.cfg[CFG_IRQ_EDGE_BIT]);
		port_change = |port_hit;
		set_flags = {pin_edge, port_change,
			timer_inc && !timer_wr && (state_reg.tmr == 8'hFF)};
		pending = state_reg.flags & state_reg.en;
		// Only enabled pin and port events can end sleep; timer rollover never does, even in counter mode
		wake_src = pending[FLAG_PIN_BIT] || pending[FLAG_PORT_BIT];
		// A write can only clear flags; a same-cycle event still sets its bit
		flags_kept = irq_flag_wr ? (state_reg.flags & work_reg[2:0]) : state_reg.flags;
	end

	// Next-state logic for the whole block. Pulses default low each cycle so
	// that nothing below has to remember to drop them; registers default to
	// holding. Control ops are single-cycle strobes from the core, so a held
	// op would repeat its action each cycle, which is the caller's concern.
	// Next-state logic for the whole block
	always_comb begin
		state_next = state_reg;
		state_next.wdt_rst = 1'b0;
		state_next.vec_valid = 1'b0;
		state_next.wake = 1'b0;
		// Pin synchronisers; first stages feed only the second stages
		state_next.cnt_s1 = ext_count_pin;
		state_next.cnt_s2 = state_reg.cnt_s1;
		state_next.cnt_prev = state_reg.cnt_s2;
		state_next.irq_s1 = ext_irq_pin;
		state_next.irq_s2 = state_reg.irq_s1;
		state_next.irq_prev = state_reg.irq_s2;
		state_next.port_s1 = second_port_pins;
		state_next.port_s2 = state_reg.port_s1;
		state_next.port_prev = state_reg.port_s2;

		if (cfg_load_op) begin
			state_next.cfg = work_reg[6:0];
		end

		// Timer count: software write wins and starts the inhibit window.
		// The window keeps a write from being overtaken by an increment that
		// was already on its way through the source path.
		if (timer_wr) begin
			state_next.tmr = timer_wdata;
			state_next.inhibit = WRITE_INHIBIT_CYCLES;
		end else begin
			if (state_reg.inhibit != 2'h0) begin
				state_next.inhibit = state_reg.inhibit - 2'h1;
			end
			if (timer_inc) begin
				state_next.tmr = state_reg.tmr + 8'h01;
			end
		end

		// Shared prescaler: clears take priority over counting
		if (timer_wr && !prescale_assign) begin
			state_next.psc = 8'h00;
		end else if (wdt_clear && prescale_assign) begin
			state_next.psc = 8'h00;
		end else if (psc_in) begin
			state_next.psc = psc_dec;
		end

		// Watchdog base counter; held clear while disabled
		if (!power_ctrl_reg[WATCHDOG_ON_BIT] || wdt_clear) begin
			state_next.wdt_cnt = 32'h0000_0000;
		end else if (wdt_base_tick) begin
			state_next.wdt_cnt = 32'h0000_0000;
		end else begin
			state_next.wdt_cnt = state_reg.wdt_cnt + 32'h0000_0001;
		end
		// A kick or sleep marks the status as clean again
		if (wdt_clear) begin
			state_next.to_n = 1'b1;
		end

		// Interrupt enables and flags
		if (irq_enable_wr) begin
			state_next.en = work_reg[2:0];
			state_next.global_irq_on = work_reg[EN_GLOBAL_BIT];
		end
		state_next.flags = flags_kept | set_flags;

		// Sleep entry and wake on an enabled pin or port-change event.
		// Wake does not depend on the global enable; that only decides
		// whether a vector follows one cycle later.
		if (sleep_op) begin
			state_next.sleeping = 1'b1;
		end else if (state_reg.sleeping && wake_src) begin
			state_next.sleeping = 1'b0;
			state_next.wake = 1'b1;
		end

		// Vectoring: hardware interrupt takes priority over the software op.
		// No hardware vector is issued while asleep; the wake pulse comes first and the
		// vector follows on the next cycle if the global enable is still set.
		if (irq_return_op) begin
			state_next.global_irq_on = 1'b1;
		end else if (state_reg.global_irq_on && (|pending) && !state_reg.sleeping) begin
			state_next.global_irq_on = 1'b0;
			state_next.vec_valid = 1'b1;
			state_next.vec_addr = IRQ_VECTOR;
		end else if (soft_irq_op) begin
			state_next.vec_valid = 1'b1;
			state_next.vec_addr = SOFT_IRQ_VECTOR;
		end

		// Watchdog time-out is a device reset; the timer count is left alone.
		// Sleep is cleared too, since a time-out in sleep restarts the core
		// rather than resuming after the sleep op.
		if (timeout) begin
			state_next.cfg = CFG_RESET;
			state_next.psc = PSC_RESET;
			state_next.inhibit = 2'h0;
			state_next.wdt_cnt = 32'h0000_0000;
			state_next.global_irq_on = 1'b0;
			state_next.en = 3'h0;
			state_next.flags = 3'h0;
			state_next.sleeping = 1'b0;
			state_next.vec_valid = 1'b0;
			state_next.wake = 1'b0;
			state_next.to_n = 1'b0;
			state_next.wdt_rst = 1'b1;
		end
	end

	// State register; the reset branch loads constants only, so the
	// asynchronous path never depends on other flops
	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
			state_reg.cfg <= CFG_RESET;
			state_reg.psc <= PSC_RESET;
			state_reg.to_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Register read paths; unused bits read as zero
	assign timer_count = state_reg.tmr;
	assign irq_enable_rdata = {state_reg.global_irq_on, 4'h0, state_reg.en};
	assign irq_flag_rdata = {5'h00, pending};

	// Status levels
	assign timeout_status_n = state_reg.to_n;
	assign sleeping = state_reg.sleeping;

	// Event pulses, each standing for one cycle, and the vector address they carry, which holds
	assign wake = state_reg.wake;
	assign vector_valid = state_reg.vec_valid;
	assign vector_addr = state_reg.vec_addr;
	assign watchdog_reset = state_reg.wdt_rst;
endmodule
`default_nettype wire

// ===== verilog/timer_irq_pkg.sv
// Purpose: Constants shared by the timer, watchdog and interrupt block.
// Assumes: One instruction cycle per clk edge at 100 MHz.
// Notes: Functional notes follow.
// Functional notes
// - 7-bit write-only config loaded from work_reg
// - Ratio field divides timer 2^(n+1), watchdog 2^n
// - Config bit 3 gives prescaler to watchdog
// - Config bit 4 one counts falling edge
// - Config bit 5 one selects external count pin
// - Config bit 6 one means rising-edge pin interrupt
// - Timer mode unprescaled increments each instruction cycle
// - Timer write blocks increments two cycles
// - Count pin synchronised before counting, small delay
// - Watchdog time-out resets device, clears status
// - Watchdog disabled when power control bit 7 low
// - Watchdog 18 ms times selected ratio
// - Kick or sleep clears watchdog and its prescaler
// - Prescaler 8-bit down counter, all ones on reset
// - Timer write clears prescaler when timer owns it
// - Taken interrupt clears global enable, vectors 008h
// - Return op sets global enable again
// - Flags set regardless of enable; read ANDs both
// - Software interrupt op vectors to 002h
// - Selected pin edge sets flag bit 2
// - Pin interrupt wakes sleep; vector if global enabled
// - Timer rollover sets flag bit 0
// - Enabled second-port change sets flag bit 1
`default_nettype none
package timer_irq_pkg;
	localparam int CFG_W = 7;
	localparam int CFG_RATIO_LSB = 0;
	localparam int CFG_ASSIGN_BIT = 3;
	localparam int CFG_EDGE_BIT = 4;
	localparam int CFG_SRC_BIT = 5;
	localparam int CFG_IRQ_EDGE_BIT = 6;
	localparam logic [6:0] CFG_RESET = 7'h3F;
	localparam logic [7:0] PSC_RESET = 8'hFF;
	localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
	localparam int EN_GLOBAL_BIT = 7;
	localparam int FLAG_TIMER_BIT = 0;
	localparam int FLAG_PORT_BIT = 1;
	localparam int FLAG_PIN_BIT = 2;
	localparam int WATCHDOG_ON_BIT = 7;
	localparam logic [11:0] IRQ_VECTOR = 12'h008;
	localparam logic [11:0] SOFT_IRQ_VECTOR = 12'h002;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WATCHDOG_TIMEOUT_NS = 18000000;
	localparam int WATCHDOG_TIMEOUT_CYCLES = WATCHDOG_TIMEOUT_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ===== tb/timer_irq_checker.sv
// Purpose: Port assertions for the timer, watchdog and interrupt block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Config is write-only, so checks lean on counts and flags.
`default_nettype none
module timer_irq_checker
	import timer_irq_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic timer_wr,
	input wire logic irq_enable_wr,
	input wire logic irq_return_op,
	input wire logic soft_irq_op,
	input wire logic [7:0] power_ctrl_reg,
	input wire logic [7:0] timer_count,
	input wire logic [7:0] irq_enable_rdata,
	input wire logic [7:0] irq_flag_rdata,
	input wire logic timeout_status_n,
	input wire logic sleeping,
	input wire logic wake,
	input wire logic vector_valid,
	input wire logic [11:0] vector_addr,
	input wire logic watchdog_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Each output is tied to its cause, so a swapped condition shows
	AST_VEC: assert property (
		vector_valid && !$past(soft_irq_op) |-> vector_addr == IRQ_VECTOR && !irq_enable_rdata[7])
		else $error("bad vector");
	AST_RET: assert property (
		irq_return_op && !irq_enable_wr |=> irq_enable_rdata[7] || watchdog_reset)
		else $error("global not set");
	AST_AND: assert property (
		(irq_flag_rdata & ~irq_enable_rdata) == 8'h00) else $error("flag read not masked");
	AST_HOLD: assert property (
		timer_wr ##1 !timer_wr [*2] |-> $stable(timer_count) ##1 $stable(timer_count))
		else $error("timer moved after write");
	AST_OVF: assert property (
		$past(timer_count) == 8'hFF && timer_count == 8'h00 && !$past(timer_wr)
		&& irq_enable_rdata[0] |-> irq_flag_rdata[0]) else $error("no overflow flag");
	AST_TO: assert property (
		watchdog_reset |-> !timeout_status_n) else $error("status not cleared");
	AST_WDOFF: assert property (
		!power_ctrl_reg[7] [*2] |=> !watchdog_reset) else $error("watchdog fired while off");
	AST_WAKE: assert property (
		wake |-> !sleeping && $past(sleeping)) else $error("wake without sleep");
	// Main scenarios reached
	cover property (vector_valid && vector_addr == SOFT_IRQ_VECTOR);
	cover property (wake);
	cover property (watchdog_reset);
endmodule
`default_nettype wire

// ===== tb/pin_source.sv
// Purpose: Far-side pins: external count clock and interrupt input.
// Assumes: Levels change just after clk rises.
// Notes: Push-pull levels, so the pins never float.
`default_nettype none
module pin_source (
	input wire logic clk,
	output logic cnt_pin,
	output logic irq_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Callers hold each level several clocks so the synchroniser sees it
	task set_cnt(input logic v);
		@(posedge clk);
		#1 cnt_pin = v;
	endtask
	task set_irq(input logic v);
		@(posedge clk);
		#1 irq_pin = v;
	endtask
	initial begin
		cnt_pin = 1'b0;
		irq_pin = 1'b0;
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the timer, watchdog and interrupt block.
// Assumes: Inputs change 1 ns after clk rises.
// Notes: Watchdog span cut to 16 cycles to keep the run short.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WDT = 16;
	logic clk, rstn, cfg_load_op, timer_wr, irq_enable_wr, irq_flag_wr, kick_watchdog_op;
	logic sleep_op, irq_return_op, soft_irq_op, ext_count_pin, ext_irq_pin;
	logic timeout_status_n, sleeping, wake, vector_valid, watchdog_reset;
	logic [7:0] work_reg, timer_wdata, power_ctrl_reg, port_change_on, second_port_pins;
	logic [7:0] timer_count, irq_enable_rdata, irq_flag_rdata, c0, d;
	logic [11:0] vector_addr;
	logic [7:0] walk[$] = '{8'hFE, 8'hFE, 8'hFE, 8'hFF, 8'h00};
	int n_fail, comparisons, wd_n, wk_n, seed;
	always #5 clk = ~clk;
	// Pulse counters sampled away from the launching edge
	always @(negedge clk) begin
		wd_n += (watchdog_reset === 1'b1);
		wk_n += (wake === 1'b1);
	end
	timer_watchdog_prescaler_irq #(.WDT_CYCLES(WDT)) dut (.*);
	pin_source src (.clk(clk), .cnt_pin(ext_count_pin), .irq_pin(ext_irq_pin));
	task automatic chk(input logic [11:0] seen, exp, input string nm);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic wr(ref logic s, input logic [7:0] v);
		work_reg = v;
		pulse(s);
	endtask
	task automatic wait_vec(input logic [11:0] a);
		for (int k = 0; k < 20 && vector_valid !== 1'b1; k++)
			cyc(1);
		chk(vector_valid, 1, "vec valid");
		chk(vector_addr, a, "vec addr");
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence; the reset config counts falling edges unprescaled
	initial begin
		{clk, rstn, cfg_load_op, timer_wr, irq_enable_wr, irq_flag_wr} = '0;
		{kick_watchdog_op, sleep_op, irq_return_op, soft_irq_op} = '0;
		{work_reg, timer_wdata, power_ctrl_reg, port_change_on, second_port_pins} = '0;
		seed = 88;
		cyc(16);
		rstn = 1'b1;
		for (int e = 0; e < 3; e++) begin
			if (e > 0)
				wr(cfg_load_op, e == 1 ? 8'h28 : 8'h38);
			c0 = timer_count;
			src.set_cnt(1'b1);
			cyc(6);
			d = timer_count - c0;
			chk(d, e == 1, "rise");
			src.set_cnt(1'b0);
			cyc(6);
			d = timer_count - c0;
			chk(d, 1, "fall");
		end
		$display("edges done");
		wr(cfg_load_op, 8'h08);
		pulse(timer_wr);
		wr(irq_enable_wr, 8'h01);
		wr(irq_flag_wr, 8'h00);
		timer_wdata = 8'hFE;
		pulse(timer_wr);
		foreach (walk[i]) begin
			chk(timer_count, walk[i], "walk");
			cyc(1);
		end
		chk(irq_flag_rdata[0], 1, "ovf");
		for (int n = 0; n < 9; n++) begin
			wr(cfg_load_op, n < 8 ? 8'(n) : 8'h08);
			timer_wdata = 8'($random(seed));
			pulse(timer_wr);
			cyc(12);
			c0 = timer_count;
			cyc(n < 8 ? 4 << (n + 1) : 4);
			d = timer_count - c0;
			chk(d, 4, "ratio");
		end
		$display("timer done");
		wr(irq_enable_wr, 8'h04);
		for (int e = 0; e < 2; e++) begin
			wr(cfg_load_op, e ? 8'h48 : 8'h08);
			wr(irq_flag_wr, 8'h00);
			src.set_irq(1'b1);
			cyc(4);
			chk(irq_flag_rdata[2], e[0], "pin rise");
			src.set_irq(1'b0);
			cyc(4);
			chk(irq_flag_rdata[2], 1, "pin fall");
		end
		wr(irq_enable_wr, 8'h00);
		chk(irq_flag_rdata, 0, "masked");
		for (int e = 1; e >= 0; e--) begin
			port_change_on = 8'($random(seed)) | 8'h01;
			wr(irq_enable_wr, 8'h02);
			wr(irq_flag_wr, 8'h00);
			second_port_pins = second_port_pins ^ (e ? (8'($random(seed)) | 8'h01) : ~port_change_on);
			cyc(5);
			chk(irq_flag_rdata[1], e[0], "port");
		end
		$display("flags done");
		wr(irq_flag_wr, 8'h00);
		wr(irq_enable_wr, 8'h84);
		src.set_irq(1'b1);
		wait_vec(12'h008);
		chk(irq_enable_rdata[7], 0, "gie vec");
		wr(irq_flag_wr, 8'h00);
		pulse(irq_return_op);
		chk(irq_enable_rdata[7], 1, "gie ret");
		pulse(soft_irq_op);
		wait_vec(12'h002);
		src.set_irq(1'b0);
		wr(irq_flag_wr, 8'h00);
		pulse(sleep_op);
		chk(sleeping, 1, "asleep");
		src.set_irq(1'b1);
		wait_vec(12'h008);
		chk(wk_n, 1, "wake");
		src.set_irq(1'b0);
		$display("irq done");
		wr(cfg_load_op, 8'h00);
		power_ctrl_reg = {1'b1, 7'($random(seed))};
		pulse(kick_watchdog_op);
		repeat (5) begin
			cyc(10);
			pulse(kick_watchdog_op);
		end
		chk(wd_n, 0, "kicked");
		cyc(WDT + 8);
		chk(wd_n, 1, "wdt fired");
		chk(timeout_status_n, 0, "status");
		power_ctrl_reg = {1'b0, 7'($random(seed))};
		wr(cfg_load_op, 8'h09);
		power_ctrl_reg = {1'b1, 7'($random(seed))};
		pulse(kick_watchdog_op);
		cyc(2 * WDT - 8);
		chk(wd_n, 1, "wdt early");
		cyc(16);
		chk(wd_n, 2, "wdt scaled");
		power_ctrl_reg = {1'b0, 7'($random(seed))};
		cyc(50);
		chk(wd_n, 2, "wdt off");
		$display("watchdog done");
		wrap_up;
	end
	// Hang guard, well past the expected run length
	initial begin
		#200000;
		n_fail++;
		wrap_up;
	end
endmodule
bind timer_watchdog_prescaler_irq timer_irq_checker chk (.*);
`default_nettype wire
